// ===== core/msp_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes a single clock; reset clears pointers only
module msp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    logic [AW:0]      wp_nxt;
    logic [AW:0]      rp_nxt;
    logic             push;
    logic             pop;

    assign in_ready  = (wp_r - rp_r) != (AW + 1)'(DEPTH);
    assign out_valid = wp_r != rp_r;
    assign out_data  = mem_r[rp_r[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (srst)
        (wp_r - rp_r) <= (AW + 1)'(DEPTH))
        else $error("fifo holds more than its depth");
    fifo_full_a: assert property (@(posedge clk) disable iff (srst)
        !in_ready |=> $stable(wp_r))
        else $error("fifo accepted a word while full");

endmodule // msp_fifo

// ===== core/msp_pkg.sv
// shared constants and types of the multibuffered serial port
// assumes one 100 MHz clock and a synchronous active-high reset
package msp_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int       CLK_MHZ      = 100;
    localparam int       SCLK_MAX_MHZ = 40;
    // shortest half period that keeps the link at or under its rate ceiling
    localparam logic [8:0] HALF_MIN   = 9'((CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ));
    localparam logic [8:0] LEAD_BASE  = 9'h002;
    localparam logic [8:0] LEAD_HOLD  = 9'h001;
    localparam logic [8:0] TRAIL_BASE = 9'h001;

    // ----------------------------------------
    // sizes and field positions
    // ----------------------------------------
    localparam int         ENTRIES    = 256;
    localparam int         IDX_W      = 8;
    localparam int         WORD_W     = 16;
    localparam int         FIFO_DEPTH = 8;
    localparam logic [3:0] LEN_M1_MIN = 4'h1;
    localparam logic [3:0] LEN_M1_MAX = 4'hF;
    localparam int         NPINS      = 4;
    localparam int         PIN_CLK    = 0;
    localparam int         PIN_COUT   = 1;
    localparam int         PIN_CIN    = 2;
    localparam int         PIN_SEL    = 3;

    // ----------------------------------------
    // types
    // ----------------------------------------
    // per-word control field of a buffer entry
    typedef struct packed {
        logic [3:0] trail;
        logic [3:0] lead;
        logic       keep_select_between_words;
        logic       phase;
        logic       polarity;
        logic       spare;
        logic [3:0] len_m1;
    } msp_ctrl_t;

    // per-word status field of a buffer entry
    typedef struct packed {
        logic [13:0] spare;
        logic        aborted;
        logic        done;
    } msp_stat_t;

    // received word as it leaves through the fifo
    typedef struct packed {
        logic [IDX_W-1:0]  idx;
        logic [WORD_W-1:0] data;
    } msp_rx_t;

    typedef enum logic [5:0] {
        MSP_IDLE  = 6'h01,
        MSP_LOAD  = 6'h02,
        MSP_LEAD  = 6'h04,
        MSP_SHIFT = 6'h08,
        MSP_TRAIL = 6'h10,
        MSP_STORE = 6'h20
    } msp_state_t;

endpackage

// ===== core/msp_port.sv
// multibuffered serial port: 256-entry buffer, shifter, pin mux
// assumes pins arrive unsynchronised and leave as input/output/enable triples
module msp_port (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // configuration
    input  wire logic                        controller_mode,
    input  wire logic [7:0]                  prescale,
    // transfer group
    input  wire logic                        grp_start,
    input  wire logic [msp_pkg::IDX_W-1:0]   grp_first,
    input  wire logic [msp_pkg::IDX_W-1:0]   grp_last,
    output logic                             busy,
    output logic                             grp_done,
    // buffer write port
    input  wire logic                        buf_wr_en,
    input  wire logic [msp_pkg::IDX_W-1:0]   buf_wr_addr,
    input  wire logic [msp_pkg::WORD_W-1:0]  buf_wr_tx,
    input  wire msp_pkg::msp_ctrl_t          buf_wr_ctrl,
    // buffer read port
    input  wire logic [msp_pkg::IDX_W-1:0]   buf_rd_addr,
    output logic      [msp_pkg::WORD_W-1:0]  buf_rd_rx,
    output msp_pkg::msp_stat_t               buf_rd_stat,
    // received word stream
    output logic                             rx_valid,
    input  wire logic                        rx_ready,
    output msp_pkg::msp_rx_t                 rx_word,
    // pins: clock, controller out, controller in, select (low active)
    input  wire logic [msp_pkg::NPINS-1:0]   pin_i,
    output logic      [msp_pkg::NPINS-1:0]   pin_o,
    output logic      [msp_pkg::NPINS-1:0]   pin_oe,
    // general-purpose use of the pins
    input  wire logic [msp_pkg::NPINS-1:0]   pin_func,
    input  wire logic [msp_pkg::NPINS-1:0]   gpio_dir,
    input  wire logic [msp_pkg::NPINS-1:0]   gpio_out,
    output logic      [msp_pkg::NPINS-1:0]   gpio_in
);
    // ----------------------------------------
    // buffer and state
    // ----------------------------------------
    logic [msp_pkg::WORD_W-1:0] tx_mem   [msp_pkg::ENTRIES];
    msp_pkg::msp_ctrl_t         ctrl_mem [msp_pkg::ENTRIES];
    logic [msp_pkg::WORD_W-1:0] rx_mem   [msp_pkg::ENTRIES];
    msp_pkg::msp_stat_t         stat_mem [msp_pkg::ENTRIES];

    msp_pkg::msp_state_t        state_r, state_nxt;
    msp_pkg::msp_ctrl_t         fmt_r, fmt_nxt;
    logic [msp_pkg::IDX_W-1:0]  idx_r, idx_nxt;
    logic [8:0]                 cnt_r, cnt_nxt;
    logic [4:0]                 edge_r, edge_nxt;
    logic [15:0]                tx_sh_r, tx_sh_nxt;
    logic [15:0]                rx_sh_r, rx_sh_nxt;
    logic                       sclk_r, sclk_nxt;
    logic                       sel_r, sel_nxt;
    logic                       held_r, held_nxt;
    logic                       abort_r, abort_nxt;
    logic                       done_r, done_nxt;
    logic [2:0]                 samp_r, samp_nxt;
    logic [msp_pkg::NPINS-1:0]  sync1_r, sync2_r, pclk_r;
    logic [msp_pkg::NPINS-1:0]  po_r, po_nxt, poe_r, poe_nxt;
    logic [msp_pkg::NPINS-1:0]  fn_o, fn_oe;

    logic [8:0]                 half_raw, half;
    logic                       ev, samp_now, store_go, fifo_in_ready;
    logic                       sel_in, din;
    msp_pkg::msp_ctrl_t         ent_ctrl;

    // ----------------------------------------
    // clock rate and edge detection
    // ----------------------------------------
    assign half_raw = {1'b0, prescale} + 9'h001;
    // rate floor protects the far party from a too-small prescale
    assign half = (half_raw < msp_pkg::HALF_MIN) ? msp_pkg::HALF_MIN : half_raw;
    assign sel_in  = !sync2_r[msp_pkg::PIN_SEL];
    // peripheral samples the controller-out line, controller the controller-in line
    assign din     = controller_mode ? sync2_r[msp_pkg::PIN_CIN] : sync2_r[msp_pkg::PIN_COUT];
    // peripheral clock edges are seen after synchronising; far clock must stay well below clk/4
    assign ev      = controller_mode ? (cnt_r == 9'h000)
                                     : (sync2_r[msp_pkg::PIN_CLK] != pclk_r[msp_pkg::PIN_CLK]);
    // controller sample waits for the edge to reach the pin and pass the synchroniser
    assign samp_now = controller_mode ? samp_r[2]
                                      : (state_r == msp_pkg::MSP_SHIFT && ev && edge_r[0] == fmt_r.phase);
    assign store_go = (state_r == msp_pkg::MSP_STORE) && fifo_in_ready;
    assign busy     = state_r != msp_pkg::MSP_IDLE;
    assign grp_done = done_r;

    always_comb begin
        ent_ctrl = ctrl_mem[idx_r];
        if (ent_ctrl.len_m1 < msp_pkg::LEN_M1_MIN) begin
            ent_ctrl.len_m1 = msp_pkg::LEN_M1_MIN;
        end
    end

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        fmt_nxt   = fmt_r;
        idx_nxt   = idx_r;
        cnt_nxt   = cnt_r;
        edge_nxt  = edge_r;
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        sclk_nxt  = sclk_r;
        sel_nxt   = sel_r;
        held_nxt  = held_r;
        abort_nxt = abort_r;
        done_nxt  = 1'b0;
        samp_nxt  = {samp_r[1:0], 1'b0};
        if (samp_now) begin
            rx_sh_nxt = {rx_sh_r[14:0], din};
        end
        case (state_r)
            msp_pkg::MSP_IDLE: begin
                sclk_nxt = fmt_r.polarity;
                if (grp_start) begin
                    idx_nxt   = grp_first;
                    state_nxt = msp_pkg::MSP_LOAD;
                end
            end
            msp_pkg::MSP_LOAD: begin
                fmt_nxt   = ent_ctrl;
                tx_sh_nxt = tx_mem[idx_r] << (msp_pkg::LEN_M1_MAX - ent_ctrl.len_m1);
                rx_sh_nxt = '0;
                edge_nxt  = '0;
                abort_nxt = 1'b0;
                sclk_nxt  = ent_ctrl.polarity;
                sel_nxt   = controller_mode;
                cnt_nxt   = {5'h00, ent_ctrl.lead} + msp_pkg::LEAD_BASE
                          + (held_r ? msp_pkg::LEAD_HOLD : 9'h000) - 9'h002;
                state_nxt = msp_pkg::MSP_LEAD;
            end
            msp_pkg::MSP_LEAD: begin
                if (controller_mode) begin
                    if (cnt_r == 9'h000) begin
                        cnt_nxt   = fmt_r.phase ? half - 9'h001 : 9'h000;
                        state_nxt = msp_pkg::MSP_SHIFT;
                    end else begin
                        cnt_nxt = cnt_r - 9'h001;
                    end
                end else if (sel_in) begin
                    state_nxt = msp_pkg::MSP_SHIFT;
                end
            end
            msp_pkg::MSP_SHIFT: begin
                if (!controller_mode && !sel_in) begin
                    abort_nxt = 1'b1;
                    state_nxt = msp_pkg::MSP_STORE;
                end else if (ev) begin
                    sclk_nxt = ~sclk_r;
                    edge_nxt = edge_r + 5'h01;
                    cnt_nxt  = half - 9'h001;
                    if (edge_r[0] == fmt_r.phase) begin
                        samp_nxt[0] = controller_mode;
                    end else if (edge_r != 5'h00) begin
                        tx_sh_nxt = {tx_sh_r[14:0], 1'b0};
                    end
                    if (edge_r == {fmt_r.len_m1, 1'b1}) begin
                        cnt_nxt = controller_mode
                                ? half + {5'h00, fmt_r.trail} + msp_pkg::TRAIL_BASE - 9'h001
                                : 9'h000;
                        state_nxt = msp_pkg::MSP_TRAIL;
                    end
                end else begin
                    cnt_nxt = cnt_r - 9'h001;
                end
            end
            msp_pkg::MSP_TRAIL: begin
                if (cnt_r == 9'h000) begin
                    sel_nxt   = controller_mode && fmt_r.keep_select_between_words;
                    held_nxt  = controller_mode && fmt_r.keep_select_between_words;
                    state_nxt = msp_pkg::MSP_STORE;
                end else begin
                    cnt_nxt = cnt_r - 9'h001;
                end
            end
            msp_pkg::MSP_STORE: begin
                // a full stream fifo holds the sequencer here
                if (fifo_in_ready) begin
                    if (idx_r == grp_last || abort_r) begin
                        sel_nxt   = 1'b0;
                        held_nxt  = 1'b0;
                        done_nxt  = 1'b1;
                        state_nxt = msp_pkg::MSP_IDLE;
                    end else begin
                        idx_nxt   = idx_r + 1'b1;
                        state_nxt = msp_pkg::MSP_LOAD;
                    end
                end
            end
            default: begin
                state_nxt = msp_pkg::MSP_IDLE;
                sel_nxt   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= msp_pkg::MSP_IDLE;
            fmt_r   <= '0;
            idx_r   <= '0;
            cnt_r   <= '0;
            edge_r  <= '0;
            tx_sh_r <= '0;
            rx_sh_r <= '0;
            sclk_r  <= 1'b0;
            sel_r   <= 1'b0;
            held_r  <= 1'b0;
            abort_r <= 1'b0;
            done_r  <= 1'b0;
            samp_r  <= '0;
        end else begin
            state_r <= state_nxt;
            fmt_r   <= fmt_nxt;
            idx_r   <= idx_nxt;
            cnt_r   <= cnt_nxt;
            edge_r  <= edge_nxt;
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            sclk_r  <= sclk_nxt;
            sel_r   <= sel_nxt;
            held_r  <= held_nxt;
            abort_r <= abort_nxt;
            done_r  <= done_nxt;
            samp_r  <= samp_nxt;
        end
    end

    // ----------------------------------------
    // buffer ports
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (buf_wr_en) begin
            tx_mem[buf_wr_addr]   <= buf_wr_tx;
            ctrl_mem[buf_wr_addr] <= buf_wr_ctrl;
        end
        if (store_go) begin
            rx_mem[idx_r]   <= rx_sh_r;
            stat_mem[idx_r] <= '{spare: '0, aborted: abort_r, done: !abort_r};
        end
        buf_rd_rx   <= rx_mem[buf_rd_addr];
        buf_rd_stat <= stat_mem[buf_rd_addr];
    end

    msp_fifo #(
        .WIDTH ($bits(msp_pkg::msp_rx_t)),
        .DEPTH (msp_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (state_r == msp_pkg::MSP_STORE),
        .in_ready  (fifo_in_ready),
        .in_data   ({idx_r, rx_sh_r}),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_word)
    );

    // ----------------------------------------
    // pins
    // ----------------------------------------
    always_comb begin
        fn_o                    = '0;
        fn_oe                   = '0;
        fn_o[msp_pkg::PIN_CLK]  = sclk_r;
        fn_o[msp_pkg::PIN_COUT] = tx_sh_r[15];
        fn_o[msp_pkg::PIN_CIN]  = tx_sh_r[15];
        fn_o[msp_pkg::PIN_SEL]  = !sel_r;
        fn_oe[msp_pkg::PIN_CLK]  = controller_mode;
        fn_oe[msp_pkg::PIN_COUT] = controller_mode;
        fn_oe[msp_pkg::PIN_SEL]  = controller_mode;
        // peripheral drives its data line only while selected
        fn_oe[msp_pkg::PIN_CIN]  = !controller_mode && sel_in;
    end

    genvar gi;
    generate
        for (gi = 0; gi < msp_pkg::NPINS; gi++) begin : g_pin
            always_comb begin
                po_nxt[gi]  = pin_func[gi] ? fn_o[gi] : gpio_out[gi];
                poe_nxt[gi] = pin_func[gi] ? fn_oe[gi] : gpio_dir[gi];
            end
            always_ff @(posedge clk) begin
                if (srst) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    pclk_r[gi]  <= 1'b0;
                    po_r[gi]    <= 1'b0;
                    poe_r[gi]   <= 1'b0;
                end else begin
                    sync1_r[gi] <= pin_i[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    pclk_r[gi]  <= sync2_r[gi];
                    po_r[gi]    <= po_nxt[gi];
                    poe_r[gi]   <= poe_nxt[gi];
                end
            end
        end
    endgenerate

    assign pin_o   = po_r;
    assign pin_oe  = poe_r;
    assign gpio_in = sync2_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [8:0] hcnt_r, lcnt_r;
    always_ff @(posedge clk) begin
        hcnt_r <= (srst || sclk_nxt != sclk_r) ? 9'h000 : hcnt_r + 9'h001;
        lcnt_r <= (state_r == msp_pkg::MSP_LEAD) ? lcnt_r + 9'h001 : 9'h000;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    word_len_a: assert property (busy && state_r != msp_pkg::MSP_LOAD |->
        fmt_r.len_m1 >= msp_pkg::LEN_M1_MIN) else $error("word shorter than two bits");
    rate_floor_a: assert property (half >= msp_pkg::HALF_MIN && half_raw == prescale + 9'h001)
        else $error("half period below rate floor");
    lead_time_a: assert property (controller_mode && state_r == msp_pkg::MSP_LEAD
        && cnt_r == 9'h000 |-> lcnt_r == {5'h00, fmt_r.lead} + msp_pkg::LEAD_BASE
        + (held_r ? msp_pkg::LEAD_HOLD : 9'h000) - 9'h002)
        else $error("lead delay length wrong");
    half_equal_a: assert property (controller_mode && state_r == msp_pkg::MSP_SHIFT
        && edge_r != 5'h00 && sclk_nxt != sclk_r |-> hcnt_r == half - 9'h001)
        else $error("unequal clock halves");
    idle_level_a: assert property (state_r == msp_pkg::MSP_LEAD
        |-> sclk_r == fmt_r.polarity) else $error("clock not at idle level");
    sel_active_a: assert property (controller_mode && state_r == msp_pkg::MSP_SHIFT
        |-> sel_r ##1 sel_r || state_r != msp_pkg::MSP_SHIFT)
        else $error("select dropped during a word");
    trail_release_a: assert property (controller_mode && state_r == msp_pkg::MSP_TRAIL
        && cnt_r == 9'h000 |=> sel_r == fmt_r.keep_select_between_words)
        else $error("select release wrong after trail");
    store_entry_a: assert property (store_go |=> ##1
        stat_mem[$past(idx_r, 2)].done == !$past(abort_r, 2))
        else $error("entry status not written");
    gpio_mux_a: assert property (!pin_func[msp_pkg::PIN_SEL] |=>
        pin_oe[msp_pkg::PIN_SEL] == $past(gpio_dir[msp_pkg::PIN_SEL]))
        else $error("gpio direction not followed");

    group_run_c: cover property (grp_start && !busy ##[1:1000] grp_done);
    held_word_c: cover property (state_r == msp_pkg::MSP_LOAD && held_r);
    fifo_stall_c: cover property (state_r == msp_pkg::MSP_STORE && !fifo_in_ready);
    abort_c: cover property (state_r == msp_pkg::MSP_SHIFT && abort_nxt && !abort_r);

endmodule // msp_port

// ===== tb/msp_far_model.sv
// far-side peripheral model: phase-0 shifter answering a fixed word
// assumes the port acts as controller; link lines arrive already resolved
module msp_far_model (
    // link lines
    input  wire logic        sclk,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    output logic             miso,
    // set-up and observation
    input  wire logic        pol,
    input  wire logic [15:0] resp,
    output logic      [15:0] got,
    output int               nlead
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] sr   = 16'h0000;
    logic        wrap = 1'b0;
    int          cnt  = 0;
    realtime     tsel = -1.0;
    initial got = 16'h0000;
    initial nlead = 0;
    // a released line shows the inverse so that a stale bit is never read as good
    assign miso = sel_n ? ~sr[15] : sr[15];
    always @(negedge sel_n) begin
        sr = resp;
        cnt = 0;
        tsel = $realtime;
    end
    // a clock move in the step that selects is the idle level settling, not an edge
    always @(sclk) begin
        if (sel_n === 1'b0 && $realtime != tsel) begin
            if (sclk !== pol) begin
                got = {got[14:0], mosi};
                nlead++;
                cnt = (cnt == 15) ? 0 : cnt + 1;
                wrap = (cnt == 0);
            end else begin
                // data moves on the trailing edge, half a period before it is sampled
                sr = wrap ? resp : {sr[14:0], 1'b0};
                wrap = 1'b0;
            end
        end
    end
endmodule // msp_far_model

// ===== tb/msp_port_test.sv
// self-checking bench of the multibuffered serial port against a far-side model
// assumes a 100 MHz clock; link tests run the port as controller, except the abort test, which runs it as peripheral
module msp_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] L = 4'h3, T = 4'h2;
    localparam int H = 4;
    logic clk = 1'b0, srst = 1'b1, mode = 1'b1, start = 1'b0, wr_en = 1'b0, rx_ready = 1'b1;
    logic [7:0] prescale = 8'h03, first = 8'h00, last = 8'h00, wr_addr = 8'h00, rd_addr = 8'h00;
    logic [15:0] wr_tx = 16'h0000, rd_rx, got, resp = 16'h3C5A;
    logic [3:0] pin_i, pin_o, pin_oe, gpio_in, pin_func = 4'hF, gpio_dir = 4'h0, gpio_out = 4'h0;
    logic [3:0] ext = 4'h8;
    logic busy, done, rx_valid, miso, pol = 1'b0, sc;
    msp_pkg::msp_ctrl_t wr_ctrl = 16'h0000;
    msp_pkg::msp_stat_t rd_stat;
    msp_pkg::msp_rx_t rx_word;
    int miscompares = 0, checks_done = 0, nlead, ts, t1, t2, tl, tr, nrise;
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & {ext[3], pin_func[2] ? miso : ext[2], ext[1:0]});
    always #5 clk = ~clk;
    msp_port uut (.clk(clk), .srst(srst), .controller_mode(mode), .prescale(prescale),
        .grp_start(start), .grp_first(first), .grp_last(last), .busy(busy), .grp_done(done),
        .buf_wr_en(wr_en), .buf_wr_addr(wr_addr), .buf_wr_tx(wr_tx), .buf_wr_ctrl(wr_ctrl),
        .buf_rd_addr(rd_addr), .buf_rd_rx(rd_rx), .buf_rd_stat(rd_stat), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_word(rx_word), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_func(pin_func), .gpio_dir(gpio_dir), .gpio_out(gpio_out), .gpio_in(gpio_in));
    msp_far_model far (.sclk(pin_o[0]), .sel_n(pin_o[3]), .mosi(pin_o[1]), .miso(miso),
        .pol(pol), .resp(resp), .got(got), .nlead(nlead));
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmpn(input string n, input int e, input int g);
        checks_done++;
        if (g != e) begin
            miscompares++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // leaves the strobe high so that back-to-back writes never toggle it in one step
    task automatic wr(input logic [7:0] a, input logic keep, input logic p, input logic [3:0] n);
        wr_addr = a;
        wr_tx = 16'hA5C3;
        wr_ctrl = {T, L, keep, 1'b0, p, 1'b0, n};
        wr_en = 1'b1;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        rd_addr = a;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // runs a group and times the pins until two cycles after its end
    task automatic run_grp(input logic [7:0] f, input logic [7:0] l);
        int c, k;
        logic ps, pc;
        c = 0; k = 0; ts = -1; t1 = -1; t2 = -1; tl = 0; tr = 0; nrise = 0; ps = 1'b1;
        wr_en = 1'b0; first = f; last = l; start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        pc = pin_o[0];
        while (k < 3 && c < 20000) begin
            @(posedge clk);
            #1 c++;
            if (done === 1'b1 || k > 0) k++;
            if (pin_o[3] === 1'b0 && ts < 0) begin
                ts = c;
                sc = pin_o[0];
            end
            // a clock move in the selecting cycle is only the idle level settling
            if (pin_o[3] === 1'b0 && ps === 1'b0 && pin_o[0] !== pc) begin
                if (t1 < 0) t1 = c;
                else if (t2 < 0) t2 = c;
                tl = c;
            end
            if (pin_o[3] === 1'b1 && ps === 1'b0) begin
                tr = c;
                nrise++;
            end
            ps = pin_o[3];
            pc = pin_o[0];
        end
        cmpn("group end in time", 1, int'(c < 20000));
    endtask
    task automatic t_word;
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            wr(8'h10, 1'b0, p[0], 4'hF);
            run_grp(8'h10, 8'h10);
            cmp("tx word", 16'hA5C3, got);
            cmp("idle level", {15'h0000, p[0]}, {15'h0000, sc});
            cmpn("lead", int'(L) + 2, t1 - ts);
            cmpn("half period", H, t2 - t1);
            cmpn("trail", H + int'(T) + 1, tr - tl);
            rd(8'h10);
            cmp("rx field", resp, rd_rx);
            cmp("done bit", 16'h0001, {15'h0000, rd_stat.done});
        end
        pol = 1'b0;
        $display("test word done");
    endtask
    task automatic t_keep;
        wr(8'hFF, 1'b1, 1'b0, 4'hF);
        run_grp(8'hFF, 8'hFF);
        cmpn("select releases with keep", 1, nrise);
        wr(8'h21, 1'b1, 1'b0, 4'hF);
        wr(8'h22, 1'b0, 1'b0, 4'hF);
        wr(8'h23, 1'b0, 1'b0, 4'hF);
        run_grp(8'h21, 8'h23);
        cmpn("select releases", 2, nrise);
        rd(8'hFF);
        cmp("entry 255", resp, rd_rx);
        rd(8'h22);
        cmp("mid entry rx", resp, rd_rx);
        $display("test keep done");
    endtask
    task automatic t_fifo;
        int n, e0;
        n = 0;
        e0 = nlead;
        for (int i = 0; i < 10; i++) wr(8'h30 + 8'(i), 1'b0, 1'b0, 4'h1);
        rx_ready = 1'b0;
        run_grp(8'h30, 8'h30);
        rx_ready = 1'b1;
        // count before the edge that pops it, or the word is gone when looked at
        for (int c = 0; c < 2000 && n < 1; c++) begin
            n += int'(rx_valid === 1'b1);
            @(posedge clk);
            #1;
        end
        cmpn("single word out", 1, n);
        rx_ready = 1'b0;
        n = 0;
        first = 8'h30; last = 8'h39; start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        repeat (1500) @(posedge clk);
        #1 cmp("stalled busy", 16'h0001, {15'h0000, busy});
        rx_ready = 1'b1;
        // the last word enters the fifo in the cycle the group ends
        for (int c = 0; c < 3000 && (busy !== 1'b0 || rx_valid === 1'b1); c++) begin
            if (rx_valid === 1'b1) begin
                cmp("stream idx", 16'h0030 + 16'(n), {8'h00, rx_word.idx});
                n++;
            end
            @(posedge clk);
            #1;
        end
        cmpn("stream count", 10, n);
        cmpn("two-bit edges", 22, nlead - e0);
        $display("test fifo done");
    endtask
    task automatic t_floor;
        prescale = 8'h00;
        wr(8'h40, 1'b0, 1'b0, 4'hF);
        run_grp(8'h40, 8'h40);
        cmpn("floored half", int'(msp_pkg::HALF_MIN), t2 - t1);
        prescale = 8'h03;
        pin_func = 4'h0; gpio_dir = 4'h3; gpio_out = 4'h2;
        repeat (4) @(posedge clk);
        #1 cmp("gpio drive", 16'h0032, {8'h00, pin_oe, pin_o[3:2] & 2'b00, pin_o[1:0]});
        cmp("gpio in", 16'h0002, {14'h0000, gpio_in[3:2]});
        pin_func = 4'hF; gpio_dir = 4'h0;
        $display("test floor gpio done");
    endtask
    // peripheral mode: the far party selects, then drops select before sending any clock edge
    task automatic t_abort;
        mode = 1'b0;
        wr(8'h50, 1'b0, 1'b0, 4'hF);
        wr_en = 1'b0;
        first = 8'h50;
        last = 8'h50;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        ext[3] = 1'b0;
        repeat (8) @(posedge clk);
        #1 ext[3] = 1'b1;
        repeat (8) @(posedge clk);
        #1 cmp("abort ends group", 16'h0000, {15'h0000, busy});
        mode = 1'b1;
        rd(8'h50);
        cmp("aborted bit", 16'h0002, {14'h0000, rd_stat.aborted, rd_stat.done});
        $display("test abort done");
    endtask
    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 cmp("busy in reset", 16'h0000, {15'h0000, busy});
        srst = 1'b0;
        @(posedge clk);
        #1;
        t_word();
        t_keep();
        t_fifo();
        t_floor();
        t_abort();
        report_and_stop();
    end
endmodule // msp_port_test
